// ### rtl/bdm_pkg.sv
/*
 * bdm_pkg: shared constants and carriers of the banked data memory and
 * special function register file.
 * assumes the core issues at most one data access per instruction cycle.
 */
package bdm_pkg;
	localparam logic [6:0] ADR_IND = 7'h00;
	localparam logic [6:0] ADR_TMR = 7'h01;
	localparam logic [6:0] ADR_PCL = 7'h02;
	localparam logic [6:0] ADR_STA = 7'h03;
	localparam logic [6:0] ADR_BNK = 7'h04;
	localparam logic [6:0] ADR_PTA = 7'h05;
	localparam logic [6:0] ADR_PTB = 7'h06;
	localparam logic [6:0] ADR_PTC = 7'h07;
	localparam logic [6:0] ADR_GP_LO = 7'h08;
	localparam int RAM_WORDS = 128;
	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_PG = 5;
	// select bit positions
	localparam int SL_PS = 0;
	localparam int SL_PSA = 3;
	localparam int SL_EDGE = 4;
	localparam int SL_SRC = 5;
	localparam int BK_SEL = 5;
	localparam logic [5:0] SEL_RST = 6'h3f;
	localparam logic [19:0] DIR_RST = 20'hfffff;
	localparam logic [10:0] PC_RST = 11'h7ff;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bdm_mem_req_type;

	typedef struct packed {
		logic upd_c;
		logic upd_z;
		logic sub;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] res;
	} bdm_alu_req_type;

	typedef enum logic [2:0] {
		PC_SEQ, PC_SCALL, PC_SJUMP, PC_LONG, PC_RET
	} bdm_pc_op_type;
endpackage

// ### rtl/bdm_sfr_file.sv
/*
 * bdm_sfr_file: banked data memory, special function registers,
 * instruction pointer, timer count and pin ports of the microcontroller.
 * assumes the execution core runs one instruction per sys_clk_i cycle and
 * drives the request structs; watchdog internals sit outside.
 */
// Overview of operation
// - configuration mode bit picks general or advanced data memory layout.
// - general mode offers 72 byte registers, upper banks through bank selection.
// - indirect port redirects to bank pointer address; pointer zero reads zero, ignores writes.
// - prescale select has no address, written from accumulator by select op.
// - prescale select holds 3f until software first writes it.
// - three ratio bits give timer 1:2..1:256 or watchdog 1:1..1:128.
// - target bit gives prescaler to watchdog when 1, timer when 0.
// - edge polarity 1 counts falling external edges, 0 rising ones.
// - source select 1 uses external timer input, 0 the instruction cycle.
// - pin direction is write-only, own op, 1 input and 0 output.
// - after reset all pins stay inputs until direction is written.
// - instruction pointer advances each cycle; jumps, calls, returns load targets.
// - page select stays unchanged when the pointer crosses into a page.
// - short call 8-bit, short jump 9-bit plus page; long forms 11-bit.
// - timer count is read/write, counts edges or cycles, synchronised input.
// - timeout and powerdown flags change by hardware only, ignore writes.
// - reset-cause flag pairs follow watchdog, sleep and power-on events; an external reset leaves them unchanged.
// - carry shows add carry-out; subtract gives 1 when no borrow.
// - nibble carry shows low-nibble carry; subtract gives 0 on nibble borrow.
// - general direct operands are 5-bit with bank bits; low bank rows alias.
// - port reads return the pin level even for output pins.
// - bank pointer bits 6..5 encode banks 0 to 3.
`timescale 1ns/1ps

// three-stage pin synchroniser; output moves only when stages two and three agree
module bdm_pin_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_o <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_o <= (s2_r & ~(s2_r ^ s3_r)) | (q_o & (s2_r ^ s3_r));
		end
	end
endmodule // bdm_pin_sync

////////////////////////////////////////////////////////////////////////////////

module bdm_sfr_file (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ext_reset_n_i,
	input wire logic cfg_adv_mode_i,
	input wire bdm_pkg::bdm_mem_req_type mem_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	input wire bdm_pkg::bdm_alu_req_type alu_i,
	input wire logic [7:0] acc_i,
	input wire logic sel_wr_i,
	input wire logic dir_wr_i,
	input wire logic [1:0] dir_port_i,
	input wire bdm_pkg::bdm_pc_op_type pc_op_i,
	input wire logic [10:0] pc_operand_i,
	input wire logic [10:0] stack_top_i,
	output logic [10:0] instr_pointer_o,
	input wire logic watchdog_clear_op_i,
	input wire logic sleep_op_i,
	input wire logic watchdog_overflow_i,
	output logic [2:0] prescale_ratio_o,
	output logic prescale_target_o,
	output logic [7:0] prescale_count_o,
	input wire logic timer_ext_input_i,
	input wire logic [19:0] pin_i,
	output logic [19:0] pin_o,
	output logic [19:0] pin_oe_o
);
	logic [7:0] ram [0:bdm_pkg::RAM_WORDS-1];
	logic [21:0] sync_q;
	logic [19:0] pin_q;
	logic ext_q;
	logic ext_q_r;
	logic soft_rst;
	logic [7:0] tmr_r;
	logic [7:0] pre_r;
	logic [7:0] pre_mask;
	logic tick;
	logic tmr_inc;
	logic [7:0] status_r;
	logic to_n_r;
	logic pd_n_r;
	logic [1:0] page_r;
	logic [2:0] alu_flag_r;
	logic [7:0] bank_r;
	logic [5:0] sel_r;
	logic [19:0] dir_r;
	logic [19:0] latch_r;
	logic [10:0] pc_r;
	logic [10:0] pc_nxt;
	logic [6:0] dir_ea;
	logic [6:0] a1;
	logic [6:0] ea;
	logic ind;
	logic null_acc;
	logic ram_hit;
	logic [7:0] rd_nxt;
	logic [8:0] sum;
	logic [4:0] nsum;
	logic [7:0] bop;

	function automatic logic [6:0] alias_adr(input logic [6:0] x, input logic adv);
		alias_adr = (!adv && x[6:5] != 2'h0 && !x[4]) ? {3'h0, x[3:0]} : x;
	endfunction

	bdm_pin_sync #(.W(22)) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.d_i({ext_reset_n_i, timer_ext_input_i, pin_i}),
		.q_o(sync_q)
	);
	assign pin_q = sync_q[19:0];
	assign ext_q = sync_q[21];
	// the filtered level starts low, so a power-on also passes through soft reset
	assign soft_rst = !ext_q;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	always_comb begin
		// general mode: 5-bit operand plus bank bits; advanced: full 7 bits
		dir_ea = cfg_adv_mode_i ? mem_i.addr : {bank_r[6:5], mem_i.addr[4:0]};
		a1 = alias_adr(dir_ea, cfg_adv_mode_i);
		ind = (a1 == bdm_pkg::ADR_IND);
		ea = ind ? alias_adr(bank_r[6:0], cfg_adv_mode_i) : a1;
		null_acc = ind && (ea == bdm_pkg::ADR_IND);
		ram_hit = (ea >= bdm_pkg::ADR_GP_LO) &&
			(!cfg_adv_mode_i || ea[4:3] != 2'h0 || ea[6:5] == 2'h0);
	end

	always_comb begin
		rd_nxt = 8'h00;
		if (null_acc) begin
			rd_nxt = 8'h00;
		end else if (ram_hit) begin
			rd_nxt = ram[ea];
		end else begin
			unique case (ea)
				bdm_pkg::ADR_TMR: rd_nxt = tmr_r;
				bdm_pkg::ADR_PCL: rd_nxt = pc_r[7:0];
				bdm_pkg::ADR_STA: rd_nxt = status_r;
				bdm_pkg::ADR_BNK: rd_nxt = bank_r;
				bdm_pkg::ADR_PTA: rd_nxt = {4'h0, pin_q[3:0]};
				bdm_pkg::ADR_PTB: rd_nxt = pin_q[11:4];
				bdm_pkg::ADR_PTC: rd_nxt = pin_q[19:12];
				default: rd_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= bdm_pkg::BYTE_RST;
			rd_valid_o <= 1'b0;
		end else begin
			rd_data_o <= mem_i.rd ? rd_nxt : rd_data_o;
			rd_valid_o <= mem_i.rd;
		end
	end

	// ram has no reset: contents are undefined until software writes them
	always_ff @(posedge sys_clk_i) begin
		if (mem_i.wr && ram_hit && !null_acc) begin
			ram[ea] <= mem_i.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bank pointer, select, direction, port latches

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bank_r <= bdm_pkg::BYTE_RST;
		end else if (soft_rst) begin
			bank_r <= bdm_pkg::BYTE_RST;
		end else if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_BNK) begin
			bank_r <= mem_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel_r <= bdm_pkg::SEL_RST;
		end else if (soft_rst) begin
			sel_r <= bdm_pkg::SEL_RST;
		end else if (sel_wr_i) begin
			sel_r <= acc_i[5:0];
		end
	end
	assign prescale_ratio_o = sel_r[bdm_pkg::SL_PS +: 3];
	assign prescale_target_o = sel_r[bdm_pkg::SL_PSA];

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dir_r <= bdm_pkg::DIR_RST;
		end else if (soft_rst) begin
			dir_r <= bdm_pkg::DIR_RST;
		end else if (dir_wr_i) begin
			unique case (dir_port_i)
				bdm_pkg::PORT_A: dir_r[3:0] <= acc_i[3:0];
				bdm_pkg::PORT_B: dir_r[11:4] <= acc_i;
				bdm_pkg::PORT_C: dir_r[19:12] <= acc_i;
				default: dir_r <= dir_r;
			endcase
		end
	end
	assign pin_oe_o = ~dir_r;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			latch_r <= '0;
		end else if (mem_i.wr && !null_acc && !ram_hit) begin
			if (ea == bdm_pkg::ADR_PTA) latch_r[3:0] <= mem_i.wdata[3:0];
			if (ea == bdm_pkg::ADR_PTB) latch_r[11:4] <= mem_i.wdata;
			if (ea == bdm_pkg::ADR_PTC) latch_r[19:12] <= mem_i.wdata;
		end
	end
	assign pin_o = latch_r;

	////////////////////////////////////////////////////////////////////////////
	// instruction pointer

	always_comb begin
		pc_nxt = pc_r + 11'h001;
		unique case (pc_op_i)
			bdm_pkg::PC_SEQ: pc_nxt = pc_r + 11'h001;
			bdm_pkg::PC_SCALL: pc_nxt = {status_r[6:5], 1'b0, pc_operand_i[7:0]};
			bdm_pkg::PC_SJUMP: pc_nxt = {status_r[6:5], pc_operand_i[8:0]};
			bdm_pkg::PC_LONG: pc_nxt = pc_operand_i;
			bdm_pkg::PC_RET: pc_nxt = stack_top_i;
			default: pc_nxt = pc_r + 11'h001;
		endcase
		if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_PCL) begin
			pc_nxt = {status_r[6:5], 1'b0, mem_i.wdata};
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_r <= bdm_pkg::PC_RST;
		end else if (soft_rst) begin
			pc_r <= bdm_pkg::PC_RST;
		end else begin
			pc_r <= pc_nxt;
		end
	end
	assign instr_pointer_o = pc_r;

	////////////////////////////////////////////////////////////////////////////
	// timer count and prescaler

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_q_r <= 1'b0;
		end else begin
			ext_q_r <= sync_q[20];
		end
	end

	always_comb begin
		if (sel_r[bdm_pkg::SL_SRC]) begin
			tick = sel_r[bdm_pkg::SL_EDGE] ? (ext_q_r && !sync_q[20])
				: (!ext_q_r && sync_q[20]);
		end else begin
			tick = 1'b1;
		end
		pre_mask = 8'((9'h002 << sel_r[bdm_pkg::SL_PS +: 3]) - 9'h001);
		tmr_inc = tick && (sel_r[bdm_pkg::SL_PSA] || (pre_r & pre_mask) == pre_mask);
	end

	// the prescaler also clears on a timer write so the next period is whole
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_r <= bdm_pkg::BYTE_RST;
		end else if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_TMR) begin
			pre_r <= bdm_pkg::BYTE_RST;
		end else if (sel_r[bdm_pkg::SL_PSA] && watchdog_clear_op_i) begin
			pre_r <= bdm_pkg::BYTE_RST;
		end else if (!sel_r[bdm_pkg::SL_PSA] && tick) begin
			pre_r <= pre_r + 8'h01;
		end
	end
	assign prescale_count_o = pre_r;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tmr_r <= bdm_pkg::BYTE_RST;
		end else if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_TMR) begin
			tmr_r <= mem_i.wdata;
		end else if (tmr_inc) begin
			tmr_r <= tmr_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status: page, reset cause, alu flags

	always_comb begin
		bop = alu_i.sub ? ~alu_i.b : alu_i.b;
		sum = {1'b0, alu_i.a} + {1'b0, bop} + {8'h00, alu_i.sub};
		nsum = {1'b0, alu_i.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, alu_i.sub};
	end

	// reset-cause flags survive the soft reset so software can tell the cause
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			to_n_r <= 1'b1;
			pd_n_r <= 1'b1;
		end else if (watchdog_overflow_i) begin
			to_n_r <= 1'b0;
		end else if (watchdog_clear_op_i) begin
			to_n_r <= 1'b1;
			pd_n_r <= 1'b1;
		end else if (sleep_op_i) begin
			to_n_r <= 1'b1;
			pd_n_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			page_r <= 2'h0;
		end else if (soft_rst) begin
			page_r <= 2'h0;
		end else if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_STA) begin
			page_r <= mem_i.wdata[6:5];
		end
	end

	// alu update is applied after a software write, so the instruction's flags win
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			alu_flag_r <= 3'h0;
		end else begin
			if (mem_i.wr && !null_acc && !ram_hit && ea == bdm_pkg::ADR_STA) begin
				alu_flag_r <= mem_i.wdata[2:0];
			end
			if (alu_i.upd_c) begin
				alu_flag_r[bdm_pkg::ST_C] <= sum[8];
				alu_flag_r[bdm_pkg::ST_DC] <= nsum[4];
			end
			if (alu_i.upd_z) begin
				alu_flag_r[bdm_pkg::ST_Z] <= (alu_i.res == 8'h00);
			end
		end
	end
	// bit 7 is unimplemented and reads 0
	assign status_r = {1'b0, page_r, to_n_r, pd_n_r, alu_flag_r};

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_ind_null;
		mem_i.rd && null_acc |=> rd_valid_o && rd_data_o == 8'h00;
	endproperty
	a_ind_null: assert property (p_ind_null) else $error("null indirect read not zero");

	property p_sel_load;
		sel_wr_i && !soft_rst |=> prescale_ratio_o == $past(acc_i[2:0]) &&
			prescale_target_o == $past(acc_i[3]);
	endproperty
	a_sel_load: assert property (p_sel_load) else $error("select load wrong");

	property p_sel_keep;
		sel_r == bdm_pkg::SEL_RST && !sel_wr_i |=> sel_r == bdm_pkg::SEL_RST;
	endproperty
	a_sel_keep: assert property (p_sel_keep) else $error("select left default");

	property p_dir_rst;
		soft_rst |=> pin_oe_o == 20'h00000;
	endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("pin driven after reset");

	property p_pg_keep;
		pc_op_i == bdm_pkg::PC_SEQ && !mem_i.wr && !soft_rst |=>
			instr_pointer_o == $past(pc_r) + 11'h001 && status_r[6:5] == $past(status_r[6:5]);
	endproperty
	a_pg_keep: assert property (p_pg_keep) else $error("sequential step wrong");

	property p_sjump;
		pc_op_i == bdm_pkg::PC_SJUMP && !mem_i.wr && !soft_rst |=>
			instr_pointer_o == {$past(status_r[6:5]), $past(pc_operand_i[8:0])};
	endproperty
	a_sjump: assert property (p_sjump) else $error("short jump target wrong");

	property p_tmr_cyc;
		!sel_r[bdm_pkg::SL_SRC] && sel_r[bdm_pkg::SL_PSA] && !mem_i.wr && !sel_wr_i ##1 !mem_i.wr |=>
			tmr_r == $past(tmr_r, 2) + 8'h02;
	endproperty
	a_tmr_cyc: assert property (p_tmr_cyc) else $error("timer not counting cycles");

	property p_flag_ro;
		!watchdog_overflow_i && !watchdog_clear_op_i && !sleep_op_i |=>
			$stable(status_r[bdm_pkg::ST_TO]) && $stable(status_r[bdm_pkg::ST_PD]);
	endproperty
	a_flag_ro: assert property (p_flag_ro) else $error("reset cause flag moved");

	property p_wdt_to;
		watchdog_overflow_i |=> !status_r[bdm_pkg::ST_TO];
	endproperty
	a_wdt_to: assert property (p_wdt_to) else $error("timeout flag not cleared");

	property p_sub_eq;
		alu_i.upd_c && alu_i.sub && alu_i.a == alu_i.b |=>
			status_r[bdm_pkg::ST_C] && status_r[bdm_pkg::ST_DC];
	endproperty
	a_sub_eq: assert property (p_sub_eq) else $error("borrow shown without borrow");

	property p_port_rd;
		mem_i.rd && !null_acc && !ram_hit && ea == bdm_pkg::ADR_PTB |=> rd_data_o == $past(pin_q[11:4]);
	endproperty
	a_port_rd: assert property (p_port_rd) else $error("port read not pin level");

	c_ind: cover property (mem_i.wr && ind && !null_acc);
	c_alias: cover property (mem_i.rd && !cfg_adv_mode_i && dir_ea[6:5] != 2'h0 && !dir_ea[4]);
	c_ext_tick: cover property (sel_r[bdm_pkg::SL_SRC] && tmr_inc);
endmodule // bdm_sfr_file

// ### tb/bdm_core.sv
/* bdm_core: stand-in for the instruction core that issues requests.
 * assumes each request is launched 1 ns after a rising edge. */
`timescale 1ns/1ps
module bdm_core (
	input wire logic sys_clk_i,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output bdm_pkg::bdm_mem_req_type mem_o,
	output bdm_pkg::bdm_alu_req_type alu_o,
	output logic [7:0] acc_o,
	output logic sel_wr_o,
	output logic dir_wr_o,
	output logic [1:0] dir_port_o,
	output bdm_pkg::bdm_pc_op_type pc_op_o,
	output logic [10:0] pc_operand_o,
	output logic [10:0] stack_top_o
);
	initial begin
		mem_o = '0;
		alu_o = '0;
		acc_o = 8'h00;
		sel_wr_o = 1'b0;
		dir_wr_o = 1'b0;
		dir_port_o = 2'h0;
		pc_op_o = bdm_pkg::PC_SEQ;
		pc_operand_o = 11'h000;
		stack_top_o = 11'h000;
	end
	task automatic step();
		@(posedge sys_clk_i);
		#1;
	endtask
	// an idle cycle follows each request, so no signal moves twice at once
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		mem_o = {1'b0, 1'b1, a, v};
		step();
		mem_o = '0;
		step();
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		mem_o = {1'b1, 1'b0, a, 8'h00};
		step();
		v = rd_valid_i ? rd_data_i : 8'hxx;
		mem_o = '0;
		step();
	endtask
	// the accumulator is scrambled once the strobe drops
	task automatic sel(input logic [7:0] v);
		acc_o = v;
		sel_wr_o = 1'b1;
		step();
		sel_wr_o = 1'b0;
		acc_o = ~v;
		step();
	endtask
	task automatic dir(input logic [1:0] p, input logic [7:0] v);
		acc_o = v;
		dir_port_o = p;
		dir_wr_o = 1'b1;
		step();
		dir_wr_o = 1'b0;
		acc_o = ~v;
		step();
	endtask
	task automatic alu(input bdm_pkg::bdm_alu_req_type r);
		alu_o = r;
		step();
		alu_o = '0;
		step();
	endtask
	task automatic pc(input bdm_pkg::bdm_pc_op_type op, input logic [10:0] v);
		pc_op_o = op;
		pc_operand_o = v;
		stack_top_o = v;
		step();
		pc_op_o = bdm_pkg::PC_SEQ;
		pc_operand_o = ~v;
		stack_top_o = ~v;
		step();
	endtask
endmodule // bdm_core

// ### tb/banked_data_memory_sfr_tb_top.sv
/* banked_data_memory_sfr_tb_top: self-checking bench of bdm_sfr_file.
 * assumes a 40 MHz instruction clock and the bdm_core stand-in. */
`timescale 1ns/1ps
module banked_data_memory_sfr_tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic ext_reset_n = 1'b1;
	logic adv = 1'b0;
	logic wd_clr = 1'b0;
	logic slp = 1'b0;
	logic wd_ovf = 1'b0;
	logic tmr_in = 1'b0;
	logic [19:0] ext_lvl = 20'h00000;
	logic [19:0] pin_w, pin_q, pin_oe;
	logic [7:0] rd_data, acc, d, d1, d2, pre_cnt;
	logic rd_valid, sel_wr, dir_wr, target;
	logic [1:0] dir_port;
	logic [2:0] ratio;
	logic [10:0] ip, pc_arg, stk;
	bdm_pkg::bdm_mem_req_type mem;
	bdm_pkg::bdm_alu_req_type alu;
	bdm_pkg::bdm_pc_op_type pc_op;
	int bad_count = 0;
	int samples_checked = 0;
	// bank written, address, data, bank read, address, expected
	logic [7:0] mr [8][6] = '{'{8'h00, 8'h08, 8'ha5, 8'h00, 8'h08, 8'ha5},
		'{8'h20, 8'h10, 8'h5a, 8'h20, 8'h10, 8'h5a}, '{8'h40, 8'h1f, 8'hc3, 8'h40, 8'h1f, 8'hc3},
		'{8'h60, 8'h15, 8'h3c, 8'h60, 8'h15, 8'h3c}, '{8'h00, 8'h10, 8'h11, 8'h20, 8'h10, 8'h5a},
		'{8'h20, 8'h08, 8'h99, 8'h00, 8'h08, 8'h99}, '{8'h31, 8'h00, 8'h77, 8'h20, 8'h11, 8'h77},
		'{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00}};
	// op code, operand, pointer one cycle after the load
	logic [10:0] pr [5][3] = '{'{11'h3, 11'h1ff, 11'h200}, '{11'h2, 11'h123, 11'h124},
		'{11'h2, 11'h123, 11'h324}, '{11'h1, 11'h0ab, 11'h2ac}, '{11'h4, 11'h5a5, 11'h5a6}};
	// {overflow, clear, sleep, timeout_n, powerdown_n}
	logic [4:0] ev [4] = '{5'b00110, 5'b10000, 5'b01011, 5'b10001};
	always #12.5 sys_clk = ~sys_clk;
	assign pin_w = (pin_oe & pin_q) | (~pin_oe & ext_lvl);
	bdm_sfr_file bdm_sfr_file_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
		.ext_reset_n_i(ext_reset_n), .cfg_adv_mode_i(adv), .mem_i(mem),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .alu_i(alu), .acc_i(acc),
		.sel_wr_i(sel_wr), .dir_wr_i(dir_wr), .dir_port_i(dir_port), .pc_op_i(pc_op),
		.pc_operand_i(pc_arg), .stack_top_i(stk), .instr_pointer_o(ip),
		.watchdog_clear_op_i(wd_clr), .sleep_op_i(slp), .watchdog_overflow_i(wd_ovf),
		.prescale_ratio_o(ratio), .prescale_target_o(target), .prescale_count_o(pre_cnt),
		.timer_ext_input_i(tmr_in), .pin_i(pin_w), .pin_o(pin_q), .pin_oe_o(pin_oe));
	bdm_core bdm_core_inst (.sys_clk_i(sys_clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
		.mem_o(mem), .alu_o(alu), .acc_o(acc), .sel_wr_o(sel_wr), .dir_wr_o(dir_wr),
		.dir_port_o(dir_port), .pc_op_o(pc_op), .pc_operand_o(pc_arg), .stack_top_o(stk));
	task automatic chk(input logic [19:0] s, input logic [19:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(2);
		reset_n = 1'b1;
		chk(pin_oe, 20'h0);
		chk(20'({target, ratio}), 20'hf);
		cyc(5);
		bdm_core_inst.wr(7'h03, 8'h60);
		bdm_core_inst.rd(7'h03, d);
		chk(20'(d[6:3]), 20'hf);
		foreach (mr[i]) begin
			bdm_core_inst.wr(7'h04, mr[i][0]);
			bdm_core_inst.wr(mr[i][1][6:0], mr[i][2]);
			bdm_core_inst.wr(7'h04, mr[i][3]);
			bdm_core_inst.rd(mr[i][4][6:0], d);
			chk(20'(d), 20'(mr[i][5]));
		end
		bdm_core_inst.dir(2'h1, 8'h0f);
		bdm_core_inst.dir(2'h0, 8'h0a);
		bdm_core_inst.dir(2'h2, 8'hff);
		ext_lvl[11:4] = 8'h0c;
		chk(pin_oe, 20'h00f05);
		bdm_core_inst.wr(7'h06, 8'ha5);
		cyc(4);
		bdm_core_inst.rd(7'h06, d);
		chk(20'(d), 20'hac);
		for (logic [3:0] r = 4'h0; r < 4'h8; r++) begin
			bdm_core_inst.sel({4'h0, r[0], r[2:0]});
			chk(20'({target, ratio}), 20'({r[0], r[2:0]}));
		end
		// reads are two cycles apart, so the count moves by 2 or 1
		for (int k = 0; k < 2; k++) begin
			bdm_core_inst.sel(k == 0 ? 8'h08 : 8'h00);
			bdm_core_inst.wr(7'h01, 8'h10);
			chk(20'(pre_cnt), 20'(k));
			bdm_core_inst.rd(7'h01, d1);
			bdm_core_inst.rd(7'h01, d2);
			chk(20'(d2 - d1), 20'(2 - k));
		end
		// two rising and one falling edge between the reads
		for (int k = 0; k < 2; k++) begin
			bdm_core_inst.sel(k == 0 ? 8'h28 : 8'h38);
			cyc(6);
			bdm_core_inst.rd(7'h01, d1);
			repeat (3) begin
				tmr_in = ~tmr_in;
				cyc(3);
			end
			cyc(8);
			bdm_core_inst.rd(7'h01, d2);
			chk(20'(d2 - d1), 20'(2 - k));
			tmr_in = 1'b0;
			cyc(8);
		end
		bdm_core_inst.alu({1'b1, 1'b1, 1'b0, 8'hf8, 8'h08, 8'h00});
		bdm_core_inst.rd(7'h03, d);
		chk(20'(d[2:0]), 20'h7);
		bdm_core_inst.alu({1'b1, 1'b1, 1'b1, 8'h50, 8'hb0, 8'ha0});
		bdm_core_inst.rd(7'h03, d);
		chk(20'(d[2:0]), 20'h2);
		bdm_core_inst.alu({1'b1, 1'b1, 1'b1, 8'h3c, 8'h3c, 8'h00});
		bdm_core_inst.rd(7'h03, d);
		chk(20'(d[2:0]), 20'h7);
		bdm_core_inst.wr(7'h03, 8'h00);
		foreach (pr[i]) begin
			if (i == 2) bdm_core_inst.wr(7'h03, 8'h20);
			bdm_core_inst.pc(bdm_pkg::bdm_pc_op_type'(pr[i][0][2:0]), pr[i][1]);
			chk(20'(ip), 20'(pr[i][2]));
		end
		bdm_core_inst.wr(7'h02, 8'h40);
		chk(20'(ip), 20'h241);
		foreach (ev[i]) begin
			{wd_ovf, wd_clr, slp} = ev[i][4:2];
			cyc(1);
			{wd_ovf, wd_clr, slp} = 3'b000;
			bdm_core_inst.rd(7'h03, d);
			chk(20'(d[4:3]), 20'(ev[i][1:0]));
		end
		ext_reset_n = 1'b0;
		cyc(6);
		ext_reset_n = 1'b1;
		cyc(8);
		bdm_core_inst.rd(7'h03, d);
		chk(20'(d[4:3]), 20'h1);
		chk(pin_oe, 20'h00000);
		chk(20'({target, ratio}), 20'hf);
		adv = 1'b1;
		bdm_core_inst.wr(7'h48, 8'h3c);
		bdm_core_inst.rd(7'h48, d1);
		bdm_core_inst.rd(7'h21, d2);
		chk(20'({d1, d2}), 20'h3c00);
		adv = 1'b0;
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		finish_test();
	end
endmodule // banked_data_memory_sfr_tb_top
